// file: verilog/bbc_slave.sv
// burst bus slave: five handshake channels over a small word memory
// ****************************************************************
// ****************************************************************
`timescale 1ns/100ps
`default_nettype none
module bbc_slave
  import bbc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               awValid,
  output logic                    awReady,
  input  wire logic [ID_W-1:0]    awId,
  input  wire logic [ADDR_W-1:0]  awAddr,
  input  wire logic [LEN_W-1:0]   awLen,
  input  wire logic [SIZE_W-1:0]  awSize,
  input  wire logic [BURST_W-1:0] awBurst,
  input  wire logic               wValid,
  output logic                    wReady,
  input  wire logic [DATA_W-1:0]  wData,
  input  wire logic [STRB_W-1:0]  wStrb,
  input  wire logic               wLast,
  output logic                    bValid,
  input  wire logic               bReady,
  output logic [ID_W-1:0]         bId,
  output logic [RESP_W-1:0]       bResp,
  input  wire logic               arValid,
  output logic                    arReady,
  input  wire logic [ID_W-1:0]    arId,
  input  wire logic [ADDR_W-1:0]  arAddr,
  input  wire logic [LEN_W-1:0]   arLen,
  input  wire logic [SIZE_W-1:0]  arSize,
  input  wire logic [BURST_W-1:0] arBurst,
  output logic                    rValid,
  input  wire logic               rReady,
  output logic [ID_W-1:0]         rId,
  output logic [DATA_W-1:0]       rData,
  output logic [RESP_W-1:0]       rResp,
  output logic                    rLast,
  output logic [USER_W-1:0]       rUser
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0]  addr,
                                                  input logic [SIZE_W-1:0]  size,
                                                  input logic [BURST_W-1:0] burst);
    logic [ADDR_W-1:0] step;
    step = ADDR_W'(1) << size;
    if (burst == BURST_FIXED) begin
      nextAddr = addr;
    end else begin
      nextAddr = addr + step;
    end
  endfunction

  function automatic logic [DATA_W-1:0] laneMask(input logic [ADDR_W-1:0] addr,
                                                  input logic [SIZE_W-1:0] size);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < STRB_W; i++) begin
      if ((i >> size) == (int'(addr[WORD_LSB-1:0]) >> size)) begin
        m[i*8 +: 8] = 8'hff;
      end
    end
    laneMask = m;
  endfunction

  function automatic logic [MEM_AW-1:0] wordIdx(input logic [ADDR_W-1:0] addr);
    wordIdx = addr[WORD_LSB +: MEM_AW];
  endfunction

  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // ****************************************************************
  // write address, data and response
  // ****************************************************************
  bbc_wr_state_t      wrState_r;
  logic               awReady_r;
  logic               wReady_r;
  logic               bValid_r;
  logic [ID_W-1:0]    bId_r;
  logic [RESP_W-1:0]  bResp_r;
  logic [ADDR_W-1:0]  wrAddr_r;
  logic [LEN_W-1:0]   wrLen_r;
  logic [SIZE_W-1:0]  wrSize_r;
  logic [BURST_W-1:0] wrBurst_r;
  logic [LEN_W-1:0]   wrCnt_r;
  logic               wrBeat;

  assign wrBeat = wValid && wReady_r;

  // address accepted whenever the idle ready is up, whatever its value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrState_r <= BBC_W_ADDR;
      awReady_r <= READY_RST;
      wReady_r  <= READY_RST;
      bValid_r  <= VALID_RST;
      bId_r     <= '0;
      bResp_r   <= RESP_OKAY;
    end else begin
      case (wrState_r)
        BBC_W_ADDR: begin
          if (awValid && awReady_r) begin
            awReady_r <= 1'b0;
            wReady_r  <= 1'b1;
            bId_r     <= awId;
            wrState_r <= BBC_W_DATA;
          end else begin
            awReady_r <= 1'b1;
          end
        end
        BBC_W_DATA: begin
          if (wrBeat && wLast) begin
            wReady_r  <= 1'b0;
            bValid_r  <= 1'b1;
            bResp_r   <= (wrCnt_r == wrLen_r) ? RESP_OKAY : RESP_SLVERR;
            wrState_r <= BBC_W_RESP;
          end
        end
        BBC_W_RESP: begin
          if (bReady) begin
            bValid_r  <= 1'b0;
            awReady_r <= 1'b1;
            wrState_r <= BBC_W_ADDR;
          end
        end
        default: begin
          awReady_r <= 1'b0;
          wReady_r  <= 1'b0;
          bValid_r  <= 1'b0;
          wrState_r <= BBC_W_ADDR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrAddr_r  <= '0;
      wrLen_r   <= '0;
      wrSize_r  <= '0;
      wrBurst_r <= BURST_FIXED;
      wrCnt_r   <= '0;
    end else if (awValid && awReady_r) begin
      wrAddr_r  <= awAddr;
      wrLen_r   <= awLen;
      wrSize_r  <= awSize;
      wrBurst_r <= awBurst;
      wrCnt_r   <= '0;
    end else if (wrBeat) begin
      wrAddr_r <= nextAddr(wrAddr_r, wrSize_r, wrBurst_r);
      wrCnt_r  <= wrCnt_r + LEN_W'(1);
    end
  end

  // strobes pick the lanes; inactive lanes keep their stored bytes
  always_ff @(posedge clk) begin
    if (wrBeat) begin
      for (int i = 0; i < STRB_W; i++) begin
        if (wStrb[i]) begin
          mem[wordIdx(wrAddr_r)][i*8 +: 8] <= wData[i*8 +: 8];
        end
      end
    end
  end

  // all outputs straight from flops, no input reaches them directly
  assign awReady = awReady_r;
  assign wReady  = wReady_r;
  assign bValid  = bValid_r;
  assign bId     = bId_r;
  assign bResp   = bResp_r;

  // ****************************************************************
  // read address and burst engine
  // ****************************************************************
  bbc_rd_state_t      rdState_r;
  logic               arReady_r;
  logic [ID_W-1:0]    rdId_r;
  logic [ADDR_W-1:0]  rdAddr_r;
  logic [LEN_W-1:0]   rdLen_r;
  logic [SIZE_W-1:0]  rdSize_r;
  logic [BURST_W-1:0] rdBurst_r;
  logic [LEN_W-1:0]   rdCnt_r;
  logic               rdBeat;

  bbc_beat_if beatBus ();

  // beats exist only inside an accepted burst
  assign beatBus.beatValid = (rdState_r == BBC_R_BURST);
  assign beatBus.beatId    = rdId_r;
  assign beatBus.beatData  = mem[wordIdx(rdAddr_r)] & laneMask(rdAddr_r, rdSize_r);
  assign beatBus.beatResp  = RESP_OKAY;
  assign beatBus.beatLast  = (rdCnt_r == rdLen_r);
  assign beatBus.beatUser  = USER_RST;
  assign rdBeat            = beatBus.beatValid && beatBus.beatReady;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdState_r <= BBC_R_IDLE;
      arReady_r <= READY_RST;
    end else begin
      case (rdState_r)
        BBC_R_IDLE: begin
          if (arValid && arReady_r) begin
            arReady_r <= 1'b0;
            rdState_r <= BBC_R_BURST;
          end else begin
            arReady_r <= 1'b1;
          end
        end
        BBC_R_BURST: begin
          if (rdBeat && beatBus.beatLast) begin
            arReady_r <= 1'b1;
            rdState_r <= BBC_R_IDLE;
          end
        end
        default: begin
          arReady_r <= 1'b0;
          rdState_r <= BBC_R_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdId_r    <= '0;
      rdAddr_r  <= '0;
      rdLen_r   <= '0;
      rdSize_r  <= '0;
      rdBurst_r <= BURST_FIXED;
      rdCnt_r   <= '0;
    end else if (arValid && arReady_r) begin
      rdId_r    <= arId;
      rdAddr_r  <= arAddr;
      rdLen_r   <= arLen;
      rdSize_r  <= arSize;
      rdBurst_r <= arBurst;
      rdCnt_r   <= '0;
    end else if (rdBeat) begin
      rdAddr_r <= nextAddr(rdAddr_r, rdSize_r, rdBurst_r);
      rdCnt_r  <= rdCnt_r + LEN_W'(1);
    end
  end

  assign arReady = arReady_r;

  bbc_rd_chan rdChan (
    .clk    (clk),
    .rst    (rst),
    .beat   (beatBus),
    .rValid (rValid),
    .rReady (rReady),
    .rId    (rId),
    .rData  (rData),
    .rResp  (rResp),
    .rLast  (rLast),
    .rUser  (rUser)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  bvalid_reset_a: assert property (disable iff (1'b0) rst |-> !bValid)
    else $error("response valid high during reset");

  bresp_hold_a: assert property (bValid && !bReady |=> bValid && $stable(bResp) && $stable(bId))
    else $error("write response changed before acceptance");

  aw_accept_a: assert property (awValid && awReady |=> !awReady && wReady)
    else $error("write address not taken while ready");

  ar_accept_a: assert property (arValid && arReady |=> rdState_r == BBC_R_BURST)
    else $error("read address not taken while ready");

  wready_idle_a: assert property (wrState_r == BBC_W_ADDR |-> !wReady)
    else $error("write ready up with no address held");

  wbeat_only_a: assert property (!(wValid && wReady) && !(awValid && awReady)
    |=> $stable(wrCnt_r))
    else $error("write beat counted without handshake");

  rvalid_cause_a: assert property ($rose(rValid) |-> $past(rdState_r) == BBC_R_BURST)
    else $error("read valid without accepted request");

  rlast_end_a: assert property (rdBeat && rdCnt_r == rdLen_r |=> rLast && arReady)
    else $error("final read beat not marked or burst not closed");

  lane_zero_a: assert property (beatBus.beatValid && rdSize_r == 3'h0 && rdAddr_r[1:0] == 2'h0
    |-> beatBus.beatData[DATA_W-1:8] == '0)
    else $error("inactive read lanes not zero");

  bresp_order_a: assert property ($rose(bValid) |-> $past(wValid && wReady && wLast))
    else $error("response before final write beat");

  wr_burst_c: cover property (wValid && wReady && wLast && wrCnt_r > 8'h0);
  rd_burst_c: cover property (rValid && rReady && rLast && rdLen_r > 8'h0);
  r_stall_c:  cover property (rValid && !rReady ##1 rValid && rReady);
  b_stall_c:  cover property (bValid && !bReady ##1 bValid && bReady);

endmodule
`default_nettype wire

// file: verilog/bbc_pkg.sv
// constants and types shared by the burst bus channel slave
package bbc_pkg;

  localparam int ID_W    = 4;
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int STRB_W  = DATA_W / 8;
  localparam int LEN_W   = 8;
  localparam int SIZE_W  = 3;
  localparam int BURST_W = 2;
  localparam int RESP_W  = 2;
  localparam int USER_W  = 1;

  // memory geometry
  localparam int MEM_DEPTH = 16;
  localparam int MEM_AW    = 4;
  localparam int WORD_LSB  = 2;

  // encodings
  localparam logic [BURST_W-1:0] BURST_FIXED = 2'h0;
  localparam logic [RESP_W-1:0]  RESP_OKAY   = 2'h0;
  localparam logic [RESP_W-1:0]  RESP_SLVERR = 2'h2;
  localparam logic [USER_W-1:0]  USER_RST    = 1'h0;

  // reset values of the handshake outputs
  localparam logic READY_RST = 1'h0;
  localparam logic VALID_RST = 1'h0;

  typedef enum logic [2:0] {
    BBC_W_ADDR = 3'h1,
    BBC_W_DATA = 3'h2,
    BBC_W_RESP = 3'h4
  } bbc_wr_state_t;

  typedef enum logic [1:0] {
    BBC_R_IDLE  = 2'h1,
    BBC_R_BURST = 2'h2
  } bbc_rd_state_t;

endpackage

// file: verilog/bbc_beat_if.sv
// read beat carrier from the burst engine to the read channel register
`timescale 1ns/100ps
`default_nettype none
interface bbc_beat_if;
  import bbc_pkg::*;
  logic                  beatValid;
  logic                  beatReady;
  logic [ID_W-1:0]       beatId;
  logic [DATA_W-1:0]     beatData;
  logic [RESP_W-1:0]     beatResp;
  logic                  beatLast;
  logic [USER_W-1:0]     beatUser;

  modport src (output beatValid, beatId, beatData, beatResp, beatLast, beatUser,
               input beatReady);
  modport dst (input beatValid, beatId, beatData, beatResp, beatLast, beatUser,
               output beatReady);
endinterface
`default_nettype wire

// file: verilog/bbc_rd_chan.sv
// read data channel output register with hold until accepted
`timescale 1ns/100ps
`default_nettype none
module bbc_rd_chan
  import bbc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  bbc_beat_if.dst                beat,
  output logic                   rValid,
  input  wire logic              rReady,
  output logic [ID_W-1:0]        rId,
  output logic [DATA_W-1:0]      rData,
  output logic [RESP_W-1:0]      rResp,
  output logic                   rLast,
  output logic [USER_W-1:0]      rUser
);

  logic rValid_r;

  // a new beat may load when none is held or in the same cycle the held one is taken
  assign beat.beatReady = !rValid_r || rReady;
  assign rValid         = rValid_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rValid_r <= VALID_RST;
    end else if (beat.beatValid && beat.beatReady) begin
      rValid_r <= 1'b1;
    end else if (rReady) begin
      rValid_r <= 1'b0;
    end
  end

  // payload only moves when a beat is loaded, so it stands while stalled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rId   <= '0;
      rData <= '0;
      rResp <= RESP_OKAY;
      rLast <= 1'b0;
      rUser <= USER_RST;
    end else if (beat.beatValid && beat.beatReady) begin
      rId   <= beat.beatId;
      rData <= beat.beatData;
      rResp <= beat.beatResp;
      rLast <= beat.beatLast;
      rUser <= beat.beatUser;
    end
  end

  rvalid_reset_a: assert property (@(posedge clk) rst |-> !rValid)
    else $error("read valid high during reset");

  rdata_hold_a: assert property (@(posedge clk) disable iff (rst)
    rValid && !rReady |=> rValid && $stable(rData) && $stable(rLast) && $stable(rId))
    else $error("read beat changed before acceptance");

endmodule
`default_nettype wire

// file: test/bbc_master_model.sv
// far side master: response and read data readiness, prompt or paced
`timescale 1ns/100ps
`default_nettype none
module bbc_master_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic bValid,
  output logic      bReady,
  input  wire logic rValid,
  output logic      rReady
);
  logic [1:0] paceCnt_r;

  // ************************************************************
  // readiness pacing
  // ************************************************************
  // paced mode drops ready three cycles in four
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      paceCnt_r <= 2'h0;
      bReady    <= 1'h0;
      rReady    <= 1'h0;
    end else begin
      paceCnt_r <= paceCnt_r + 2'h1;
      bReady    <= !slow || (paceCnt_r == 2'h3);
      rReady    <= !slow || (paceCnt_r == 2'h1);
    end
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the burst bus channel slave
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import bbc_pkg::*;
  logic               clk, rst, slow;
  logic               awValid, awReady, wValid, wReady, wLast, bValid, bReady;
  logic               arValid, arReady, rValid, rReady, rLast;
  logic [ID_W-1:0]    awId, bId, arId, rId;
  logic [ADDR_W-1:0]  awAddr, arAddr;
  logic [LEN_W-1:0]   awLen, arLen;
  logic [SIZE_W-1:0]  awSize, arSize;
  logic [BURST_W-1:0] awBurst, arBurst;
  logic [DATA_W-1:0]  wData, rData;
  logic [STRB_W-1:0]  wStrb;
  logic [RESP_W-1:0]  bResp, rResp;
  logic [USER_W-1:0]  rUser;
  logic [DATA_W-1:0]  mem [MEM_DEPTH];
  int                 n_errors, total_checks;

  bbc_slave bbc_slave_i (
    .clk     (clk),
    .rst     (rst),
    .awValid (awValid),
    .awReady (awReady),
    .awId    (awId),
    .awAddr  (awAddr),
    .awLen   (awLen),
    .awSize  (awSize),
    .awBurst (awBurst),
    .wValid  (wValid),
    .wReady  (wReady),
    .wData   (wData),
    .wStrb   (wStrb),
    .wLast   (wLast),
    .bValid  (bValid),
    .bReady  (bReady),
    .bId     (bId),
    .bResp   (bResp),
    .arValid (arValid),
    .arReady (arReady),
    .arId    (arId),
    .arAddr  (arAddr),
    .arLen   (arLen),
    .arSize  (arSize),
    .arBurst (arBurst),
    .rValid  (rValid),
    .rReady  (rReady),
    .rId     (rId),
    .rData   (rData),
    .rResp   (rResp),
    .rLast   (rLast),
    .rUser   (rUser)
  );
  bbc_master_model bbc_master_model_i (
    .clk    (clk),
    .rst    (rst),
    .slow   (slow),
    .bValid (bValid),
    .bReady (bReady),
    .rValid (rValid),
    .rReady (rReady)
  );

  always #20 clk = ~clk;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // waits for a handshake edge: 0 aw, 1 w, 2 ar, 3 b, 4 r
  task automatic hs(input int ch);
    int   t;
    logic hit;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      case (ch)
        0: hit = awReady;
        1: hit = wReady;
        2: hit = arReady;
        3: hit = bValid && bReady;
        default: hit = rValid && rReady;
      endcase
    end while (hit !== 1'b1 && t < 40);
    check(hit, 1, "handshake timeout");
  endtask

  // byte lane mask from a strobe
  function automatic logic [31:0] lanes(input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      lanes[i*8 +: 8] = {8{strb[i]}};
    end
  endfunction

  // first beat is raised with the address, not after it
  task automatic wr(input logic [3:0] id, input logic [11:0] addr, input int len,
                    input int beats, input logic [1:0] resp, input logic [1:0] burst,
                    input logic [3:0] strb);
    int          k;
    logic [3:0]  wi;
    logic [31:0] m;
    m = lanes(strb);
    @(negedge clk);
    awValid = 1;
    awId    = id;
    awAddr  = addr;
    awLen   = len[7:0];
    awSize  = 3'h2;
    awBurst = burst;
    wValid  = 1;
    wStrb   = strb;
    for (k = 0; k < beats; k++) begin
      if (k > 0) begin
        @(negedge clk);
      end
      wData = (32'h5a000000 ^ (id << 16) ^ (addr << 4) ^ k) & m;
      wLast = (k == beats - 1);
      if (k == 0) begin
        hs(0);
        @(negedge clk);
        awValid = 0;
        awAddr  = ~addr;
      end
      hs(1);
      wi      = (burst == BURST_FIXED) ? addr[5:2] : addr[5:2] + k[3:0];
      mem[wi] = (mem[wi] & ~m) | wData;
    end
    @(negedge clk);
    wValid = 0;
    wData  = ~wData;
    check(wReady, 0, "data ready after last beat");
    check(bValid, 1, "response valid after last beat");
    hs(3);
    check(bId, id, "response id");
    check(bResp, resp, "response code");
  endtask

  task automatic rd(input logic [3:0] id, input logic [11:0] addr, input int len,
                    input logic [2:0] size, input logic [1:0] burst);
    int          k;
    logic [3:0]  ri;
    logic [31:0] exp;
    @(negedge clk);
    arValid = 1;
    arId    = id;
    arAddr  = addr;
    arLen   = len[7:0];
    arSize  = size;
    arBurst = burst;
    hs(2);
    @(negedge clk);
    arValid = 0;
    arAddr  = ~addr;
    check(arReady, 0, "read address refused while busy");
    check(rValid, 0, "read data one cycle after request");
    for (k = 0; k <= len; k++) begin
      hs(4);
      ri  = (burst == BURST_FIXED) ? addr[5:2] : addr[5:2] + k[3:0];
      exp = (size == 3'h2) ? mem[ri] : (mem[ri] & 32'h000000ff);
      check(rData, exp, "read data");
      check(rId, id, "read id");
      check(rLast, k == len, "read last flag");
      check(rResp, RESP_OKAY, "read response");
      check(rUser, USER_RST, "read user");
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check(rValid, 0, "read valid in reset");
    check(bValid, 0, "response valid in reset");
    rst = 0;
    repeat (2) @(posedge clk);
    repeat (4) begin
      @(negedge clk);
      check(awReady, 1, "idle write address ready");
      check(arReady, 1, "idle read address ready");
      check(rValid, 0, "read valid without request");
    end
    $display("test reset done");
  endtask

  task automatic t_burst;
    wr(4'h3, 12'h010, 3, 4, RESP_OKAY, 2'h1, 4'hf);
    rd(4'h5, 12'h010, 3, 3'h2, 2'h1);
    $display("test burst done");
  endtask

  task automatic t_slow_wrap;
    slow = 1;
    wr(4'h9, 12'h03c, 1, 2, RESP_OKAY, 2'h1, 4'hf);
    rd(4'ha, 12'h03c, 1, 3'h2, 2'h1);
    slow = 0;
    $display("test slow wrap done");
  endtask

  task automatic t_bad_count;
    wr(4'h6, 12'h020, 2, 2, RESP_SLVERR, 2'h1, 4'hf);
    $display("test bad count done");
  endtask

  task automatic t_narrow;
    rd(4'h1, 12'h014, 0, 3'h0, 2'h1);
    $display("test narrow done");
  endtask

  // fixed burst rewrites one word through partial strobes
  task automatic t_fixed_lanes;
    wr(4'h7, 12'h024, 1, 2, RESP_OKAY, BURST_FIXED, 4'h5);
    rd(4'h8, 12'h024, 1, 3'h2, BURST_FIXED);
    $display("test fixed lanes done");
  endtask

  // reset lands while a read beat is still waiting
  task automatic t_mid_reset;
    slow = 1;
    @(negedge clk);
    arValid = 1;
    arId    = 4'h2;
    arAddr  = 12'h010;
    arLen   = 8'h3;
    arSize  = 3'h2;
    arBurst = 2'h1;
    hs(2);
    @(negedge clk);
    arValid = 0;
    @(negedge clk);
    check(rValid, 1, "read beat pending before reset");
    rst = 1;
    @(negedge clk);
    check(rValid, 0, "read valid in mid-run reset");
    check(bValid, 0, "response valid in mid-run reset");
    repeat (2) @(negedge clk);
    rst  = 0;
    slow = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(awReady, 1, "write address ready after reset");
    check(arReady, 1, "read address ready after reset");
    rd(4'h4, 12'h010, 3, 3'h2, 2'h1);
    $display("test mid reset done");
  endtask

  initial begin
    clk     = 0;
    rst     = 1;
    slow    = 0;
    awValid = 0;
    wValid  = 0;
    arValid = 0;
    {awId, awAddr, awLen, awSize, awBurst} = '0;
    {wData, wStrb, wLast} = '0;
    {arId, arAddr, arLen, arSize, arBurst} = '0;
    n_errors     = 0;
    total_checks = 0;
    foreach (mem[i]) mem[i] = '0;
    t_reset();
    t_burst();
    t_slow_wrap();
    t_bad_count();
    t_narrow();
    t_fixed_lanes();
    t_mid_reset();
    complete_run();
  end

  initial begin
    #(40 * 4000);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
